// ===== inc/pfl_defines.vh
/*
  Command codes, reset values and timing constants of the paged
  fault and limit command bank.
  Assumes a 20 MHz core clock and a management bus front end that
  decodes the command code and the page selection.
*/
`ifndef PFL_DEFINES_VH
`define PFL_DEFINES_VH

`define PFL_CLK_NS 50
`define PFL_UV_DLY_NS 5000

`define PFL_C_GAIN 8'h38
`define PFL_C_OFFS 8'h39
`define PFL_C_VOOV_F 8'h40
`define PFL_C_VOOV_A 8'h41
`define PFL_C_VOOV_W 8'h42
`define PFL_C_VOUV_W 8'h43
`define PFL_C_VOUV_F 8'h44
`define PFL_C_VOUV_A 8'h45
`define PFL_C_OOC_F 8'h46
`define PFL_C_OOC_A 8'h47
`define PFL_C_OOC_W 8'h4a
`define PFL_C_OT_F 8'h4f
`define PFL_C_OT_A 8'h50
`define PFL_C_OT_W 8'h51
`define PFL_C_INOV_F 8'h55
`define PFL_C_INOV_A 8'h56
`define PFL_C_INOV_W 8'h57
`define PFL_C_INUV_W 8'h58
`define PFL_C_INUV_F 8'h59
`define PFL_C_INUV_A 8'h5a
`define PFL_C_IOC_F 8'h5b
`define PFL_C_IOC_A 8'h5c
`define PFL_C_IOC_W 8'h5d
`define PFL_C_ON_DLY 8'h60
`define PFL_C_ON_RMP 8'h61
`define PFL_C_ON_MAX 8'h62
`define PFL_C_ON_MAX_A 8'h63
`define PFL_C_OFF_DLY 8'h64
`define PFL_C_OFF_RMP 8'h65
`define PFL_C_PWR_W 8'h6b
`define PFL_C_STS_BYTE 8'h78
`define PFL_C_STS_WORD 8'h79
`define PFL_C_STS_VOUT 8'h7a

`define PFL_R_GAIN 16'hca80
`define PFL_R_OFFS_A 16'he801
`define PFL_R_OFFS_B 16'he800
`define PFL_R_VOOV_F_A 16'h044a
`define PFL_R_VOOV_F_B 16'h04c5
`define PFL_R_VOOV_W_A 16'h0429
`define PFL_R_VOOV_W_B 16'h04a4
`define PFL_R_VOUV_W_A 16'h02d1
`define PFL_R_VOUV_W_B 16'h034c
`define PFL_R_VOUV_F_A 16'h02c0
`define PFL_R_VOUV_F_B 16'h033b
`define PFL_R_OOC_F_A 16'h10e0
`define PFL_R_OOC_F_B 16'h0050
`define PFL_R_OOC_W_A 16'h01b8
`define PFL_R_OOC_W_B 16'h003c
`define PFL_R_ACT_LATCH 16'h0080
`define PFL_R_ACT_DELAY 16'h0040
`define PFL_R_ACT_OC 16'h00c0
`define PFL_R_OT_F 16'h0078
`define PFL_R_OT_W 16'h006e
`define PFL_R_INOV_F 16'h000f
`define PFL_R_INOV_W 16'h000e
`define PFL_R_INUV_W 16'hf022
`define PFL_R_INUV_F 16'hf020
`define PFL_R_IOC_F 16'h0034
`define PFL_R_IOC_W 16'h002c
`define PFL_R_TDLY 16'hf800
`define PFL_R_RAMP 16'hf006
`define PFL_R_ON_MAX 16'hf008
`define PFL_R_PWR_W 16'h0928

`endif

// ===== design/pfl_bank.v
/*
  Paged fault and limit command bank for a two channel controller.
  Holds per channel limits, fault actions and ramp settings, latches
  channels off on faults and reports summary and output status.
  Assumes the command port and channel enables come from logic on
  sys_clk_i, while the fault comparator flags arrive asynchronously.
*/
`timescale 1ns/1ps
`include "pfl_defines.vh"

module pfl_bank (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        cmd_vld_i,
  input  wire        cmd_wr_i,
  input  wire [7:0]  cmd_code_i,
  input  wire [15:0] cmd_wdata_i,
  input  wire        page_i,
  input  wire [1:0]  chan_en_i,
  input  wire [17:0] chan_flt_i,
  input  wire [6:0]  in_flt_i,
  output reg  [15:0] rsp_data_o,
  output reg         rsp_vld_o,
  output reg         cmd_err_o,
  output wire [1:0]  chan_off_o
);

  // The undervoltage delay is rounded up to whole clock cycles.
  localparam integer UV_DLY_CYC =
    (`PFL_UV_DLY_NS + `PFL_CLK_NS - 1) / `PFL_CLK_NS;
  localparam integer UV_LAST = UV_DLY_CYC - 1;

  // Map result: {known, common to both pages, byte wide, index}.
  function [7:0] cmd_map;
    input [7:0] code;
    begin
      case (code)
        `PFL_C_GAIN:     cmd_map = {3'b100, 5'd0};
        `PFL_C_OFFS:     cmd_map = {3'b100, 5'd1};
        `PFL_C_VOOV_F:   cmd_map = {3'b100, 5'd2};
        `PFL_C_VOOV_A:   cmd_map = {3'b101, 5'd3};
        `PFL_C_VOOV_W:   cmd_map = {3'b100, 5'd4};
        `PFL_C_VOUV_W:   cmd_map = {3'b100, 5'd5};
        `PFL_C_VOUV_F:   cmd_map = {3'b100, 5'd6};
        `PFL_C_VOUV_A:   cmd_map = {3'b101, 5'd7};
        `PFL_C_OOC_F:    cmd_map = {3'b100, 5'd8};
        `PFL_C_OOC_A:    cmd_map = {3'b101, 5'd9};
        `PFL_C_OOC_W:    cmd_map = {3'b100, 5'd10};
        `PFL_C_OT_F:     cmd_map = {3'b100, 5'd11};
        `PFL_C_OT_A:     cmd_map = {3'b101, 5'd12};
        `PFL_C_OT_W:     cmd_map = {3'b100, 5'd13};
        `PFL_C_INOV_F:   cmd_map = {3'b110, 5'd14};
        `PFL_C_INOV_A:   cmd_map = {3'b111, 5'd15};
        `PFL_C_INOV_W:   cmd_map = {3'b110, 5'd16};
        `PFL_C_INUV_W:   cmd_map = {3'b110, 5'd17};
        `PFL_C_INUV_F:   cmd_map = {3'b110, 5'd18};
        `PFL_C_INUV_A:   cmd_map = {3'b111, 5'd19};
        `PFL_C_IOC_F:    cmd_map = {3'b110, 5'd20};
        `PFL_C_IOC_A:    cmd_map = {3'b111, 5'd21};
        `PFL_C_IOC_W:    cmd_map = {3'b110, 5'd22};
        `PFL_C_ON_DLY:   cmd_map = {3'b100, 5'd23};
        `PFL_C_ON_RMP:   cmd_map = {3'b100, 5'd24};
        `PFL_C_ON_MAX:   cmd_map = {3'b100, 5'd25};
        `PFL_C_ON_MAX_A: cmd_map = {3'b101, 5'd26};
        `PFL_C_OFF_DLY:  cmd_map = {3'b100, 5'd27};
        `PFL_C_OFF_RMP:  cmd_map = {3'b100, 5'd28};
        `PFL_C_PWR_W:    cmd_map = {3'b110, 5'd29};
        default:         cmd_map = 8'h00;
      endcase
    end
  endfunction

  // Reset contents; bit 5 of the slot selects channel B.
  function [15:0] rst_val;
    input [5:0] slot;
    begin
      case (slot[4:0])
        5'd0:  rst_val = `PFL_R_GAIN;
        5'd1:  rst_val = slot[5] ? `PFL_R_OFFS_B : `PFL_R_OFFS_A;
        5'd2:  rst_val = slot[5] ? `PFL_R_VOOV_F_B : `PFL_R_VOOV_F_A;
        5'd3:  rst_val = `PFL_R_ACT_LATCH;
        5'd4:  rst_val = slot[5] ? `PFL_R_VOOV_W_B : `PFL_R_VOOV_W_A;
        5'd5:  rst_val = slot[5] ? `PFL_R_VOUV_W_B : `PFL_R_VOUV_W_A;
        5'd6:  rst_val = slot[5] ? `PFL_R_VOUV_F_B : `PFL_R_VOUV_F_A;
        5'd7:  rst_val = `PFL_R_ACT_DELAY;
        5'd8:  rst_val = slot[5] ? `PFL_R_OOC_F_B : `PFL_R_OOC_F_A;
        5'd9:  rst_val = `PFL_R_ACT_OC;
        5'd10: rst_val = slot[5] ? `PFL_R_OOC_W_B : `PFL_R_OOC_W_A;
        5'd11: rst_val = `PFL_R_OT_F;
        5'd12: rst_val = `PFL_R_ACT_LATCH;
        5'd13: rst_val = `PFL_R_OT_W;
        5'd14: rst_val = `PFL_R_INOV_F;
        5'd15: rst_val = `PFL_R_ACT_LATCH;
        5'd16: rst_val = `PFL_R_INOV_W;
        5'd17: rst_val = `PFL_R_INUV_W;
        5'd18: rst_val = `PFL_R_INUV_F;
        5'd19: rst_val = `PFL_R_ACT_LATCH;
        5'd20: rst_val = `PFL_R_IOC_F;
        5'd21: rst_val = `PFL_R_ACT_OC;
        5'd22: rst_val = `PFL_R_IOC_W;
        5'd23: rst_val = `PFL_R_TDLY;
        5'd24: rst_val = `PFL_R_RAMP;
        5'd25: rst_val = `PFL_R_ON_MAX;
        5'd26: rst_val = `PFL_R_ACT_LATCH;
        5'd27: rst_val = `PFL_R_TDLY;
        5'd28: rst_val = `PFL_R_RAMP;
        5'd29: rst_val = `PFL_R_PWR_W;
        default: rst_val = 16'h0000;
      endcase
    end
  endfunction

  reg  [15:0] cfg_ff [0:63];
  reg  [24:0] sync1_ff;
  reg  [24:0] sync2_ff;
  reg  [6:0]  in_sts_ff;
  wire [8:0]  ch_sts   [0:1];
  wire [1:0]  ch_off;
  wire [7:0]  map;
  wire        known;
  wire        common;
  wire        byte_w;
  wire        ch_sel;
  wire [5:0]  slot;
  wire        is_byte;
  wire        is_word;
  wire        is_vout;
  wire        wr_cfg;
  wire        wr_word;
  wire        wr_vout;
  wire [6:0]  in_flt;
  wire [2:0]  in_trip;
  wire [8:0]  sel_sts;
  wire        sel_off;
  wire [7:0]  sts_byte;
  wire [7:0]  sts_hi;
  wire [7:0]  sts_vout;
  reg  [15:0] nxt_rdata;
  reg         nxt_err;
  integer     i;

  assign map     = cmd_map(cmd_code_i);
  assign known   = map[7];
  assign common  = map[6];
  assign byte_w  = map[5];
  assign ch_sel  = common ? 1'b0 : page_i;
  assign slot    = {ch_sel, map[4:0]};
  assign is_byte = cmd_code_i == `PFL_C_STS_BYTE;
  assign is_word = cmd_code_i == `PFL_C_STS_WORD;
  assign is_vout = cmd_code_i == `PFL_C_STS_VOUT;
  assign wr_cfg  = cmd_vld_i & cmd_wr_i & known;
  assign wr_word = cmd_vld_i & cmd_wr_i & is_word;
  assign wr_vout = cmd_vld_i & cmd_wr_i & is_vout;
  assign in_flt  = sync2_ff[24:18];

  // The comparators run on their own timing, so every flag is
  // resynchronised before any decision is taken on it.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 25'h0000000;
      sync2_ff <= 25'h0000000;
    end else begin
      sync1_ff <= {in_flt_i, chan_flt_i};
      sync2_ff <= sync1_ff;
    end
  end

  // Input side commands keep a single copy, so their page bit is
  // forced low. Byte wide commands keep only the low write byte.
  // Ramp and delay settings are stored only; this bank does not act.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (i = 0; i < 64; i = i + 1) begin
        cfg_ff[i] <= rst_val(i[5:0]);
      end
    end else if (wr_cfg) begin
      cfg_ff[slot] <= byte_w ? {8'h00, cmd_wdata_i[7:0]} : cmd_wdata_i;
    end
  end

  // Input side faults are shared, so they trip both channels.
  assign in_trip[0] = in_flt[0] & (cfg_ff[15][7:6] != 2'b00);
  assign in_trip[1] = in_flt[3] & (cfg_ff[19][7:6] != 2'b00);
  assign in_trip[2] = in_flt[4] & (cfg_ff[21][7:6] != 2'b00);

  // Input status is sticky; an event in the clearing cycle survives.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_sts_ff <= 7'h00;
    end else begin
      in_sts_ff <= (wr_word ? 7'h00 : in_sts_ff) | in_flt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_ch
      // Each channel keeps its own status, delay count and latch.
      wire [8:0] flt;
      wire       uv_act_dly;
      wire       uv_act_now;
      wire       trip;
      wire       clr;
      reg  [8:0] sts_ff;
      reg  [6:0] dly_ff;
      reg        lat_ff;

      assign flt = sync2_ff[9*g +: 9];
      assign uv_act_dly = cfg_ff[g*32+7][7:6] == 2'b01;
      assign uv_act_now = cfg_ff[g*32+7][7];
      assign clr = (wr_word & (page_i == g)) | ~chan_en_i[g];
      // An action field of 00 ignores the fault; 01 delays only the
      // undervoltage trip, and any other code trips at once.
      assign trip =
        (flt[0] & (cfg_ff[g*32+3][7:6] != 2'b00)) |
        (flt[3] & uv_act_now) |
        (flt[3] & uv_act_dly & (dly_ff == UV_LAST[6:0])) |
        (flt[4] & (cfg_ff[g*32+9][7:6] != 2'b00)) |
        (flt[6] & (cfg_ff[g*32+12][7:6] != 2'b00)) |
        (flt[8] & (cfg_ff[g*32+26][7:6] != 2'b00)) |
        (|in_trip);

      // The delay only runs while the undervoltage persists.
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          dly_ff <= 7'h00;
        end else if (flt[3] & uv_act_dly & ~lat_ff) begin
          if (dly_ff != UV_LAST[6:0]) begin
            dly_ff <= dly_ff + 7'h01;
          end
        end else begin
          dly_ff <= 7'h00;
        end
      end

      // No automatic restart: only a status word write or a dropped enable releases the latch.
      // Set wins over a status word clear, so a fault in that clearing cycle latches; a dropped enable always clears.
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          lat_ff <= 1'b0;
        end else if (trip & chan_en_i[g]) begin
          lat_ff <= 1'b1;
        end else if (clr) begin
          lat_ff <= 1'b0;
        end
      end

      // Status is sticky; a fault present in the clearing cycle stays
      // set, so the host never loses an event that raced its clear.
      always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          sts_ff <= 9'h000;
        end else begin
          if (wr_word & (page_i == g)) begin
            sts_ff <= flt;
          end else if (wr_vout & (page_i == g)) begin
            sts_ff <= (sts_ff & 9'h0f0) | flt;
          end else begin
            sts_ff <= sts_ff | flt;
          end
        end
      end

      assign ch_sts[g] = sts_ff;
      assign ch_off[g] = lat_ff;
    end
  endgenerate

  assign chan_off_o = ch_off;

  // Status views; the summary byte is the low half of the word.
  // A channel that is not enabled reports off, whatever its latch holds.
  assign sel_sts  = ch_sts[page_i];
  assign sel_off  = ch_off[page_i] | ~chan_en_i[page_i];
  assign sts_byte = {1'b0,
                     sel_off,
                     sel_sts[0],
                     sel_sts[4],
                     in_sts_ff[3],
                     sel_sts[6] | sel_sts[7],
                     1'b0,
                     1'b0};
  assign sts_hi   = {|sel_sts[3:0] | sel_sts[8],
                     sel_sts[5] | sel_sts[4],
                     |in_sts_ff[5:0],
                     1'b0,
                     sel_off,
                     3'b000};
  assign sts_vout = {sel_sts[0],
                     sel_sts[1],
                     sel_sts[2],
                     sel_sts[3],
                     1'b0,
                     sel_sts[8],
                     2'b00};

  // Unknown codes and writes to the summary byte are refused, and a
  // refused read answers zero so no stale word reaches the host.
  always @* begin
    nxt_rdata = 16'h0000;
    nxt_err = 1'b0;
    if (known) begin
      nxt_rdata = cfg_ff[slot];
    end else if (is_byte) begin
      nxt_rdata = {8'h00, sts_byte};
      nxt_err = cmd_wr_i;
    end else if (is_word) begin
      nxt_rdata = {sts_hi, sts_byte};
    end else if (is_vout) begin
      nxt_rdata = {8'h00, sts_vout};
    end else begin
      nxt_err = 1'b1;
    end
  end

  // Answers are registered so the front end sees them one cycle on.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_data_o <= 16'h0000;
      rsp_vld_o <= 1'b0;
      cmd_err_o <= 1'b0;
    end else begin
      rsp_vld_o <= cmd_vld_i & ~cmd_wr_i & ~nxt_err;
      cmd_err_o <= cmd_vld_i & nxt_err;
      if (cmd_vld_i & ~cmd_wr_i) begin
        rsp_data_o <= nxt_err ? 16'h0000 : nxt_rdata;
      end
    end
  end

endmodule

// ===== verification/pfl_bank_chk.sv
/*
  Port checker for the paged command bank, bound to pfl_bank.
  Assumes one clock domain and an active high reset.
*/
`timescale 1ns/1ps
module pfl_bank_chk (
  input wire        sys_clk_i,
  input wire        rst_i,
  input wire        cmd_vld_i,
  input wire        cmd_wr_i,
  input wire [7:0]  cmd_code_i,
  input wire [15:0] cmd_wdata_i,
  input wire        page_i,
  input wire [1:0]  chan_en_i,
  input wire [17:0] chan_flt_i,
  input wire [6:0]  in_flt_i,
  input wire [15:0] rsp_data_o,
  input wire        rsp_vld_o,
  input wire        cmd_err_o,
  input wire [1:0]  chan_off_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_RSP_CAUSE: assert property (
    rsp_vld_o |-> $past(cmd_vld_i && !cmd_wr_i)) else $error("stray answer");
  AST_BYTE_RO: assert property (
    cmd_vld_i && cmd_wr_i && cmd_code_i == 8'h78 |=> cmd_err_o)
    else $error("status byte write not refused");
  AST_UNK_CODE: assert property (
    cmd_vld_i && cmd_code_i == 8'h00 |=> cmd_err_o && !rsp_vld_o)
    else $error("unknown code not refused");
  AST_RD_LIMIT: assert property (
    cmd_vld_i && !cmd_wr_i && cmd_code_i == 8'h40 |=> rsp_vld_o && !cmd_err_o)
    else $error("limit read not answered");
  AST_WR_QUIET: assert property (
    cmd_vld_i && cmd_wr_i |=> !rsp_vld_o) else $error("write answered");
  AST_DATA_HOLD: assert property (
    !(cmd_vld_i && !cmd_wr_i) |=> $stable(rsp_data_o))
    else $error("read data moved without a read");
  AST_OFF_HOLD: assert property (
    chan_off_o[0] && chan_en_i[0] && !(cmd_vld_i && cmd_wr_i &&
    cmd_code_i == 8'h79 && !page_i) |=> chan_off_o[0])
    else $error("latched channel restarted");
  AST_EN_CLR: assert property (
    !chan_en_i[0] |=> !chan_off_o[0]) else $error("latch kept while disabled");
  AST_OV_IMM: assert property (
    (chan_flt_i[0] && chan_en_i[0]) [*3] |=> chan_off_o[0])
    else $error("overvoltage fault did not latch off");
endmodule

bind pfl_bank pfl_bank_chk chk_u (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_vld_i(cmd_vld_i),
  .cmd_wr_i(cmd_wr_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
  .page_i(page_i), .chan_en_i(chan_en_i), .chan_flt_i(chan_flt_i),
  .in_flt_i(in_flt_i), .rsp_data_o(rsp_data_o), .rsp_vld_o(rsp_vld_o),
  .cmd_err_o(cmd_err_o), .chan_off_o(chan_off_o)
);

// ===== verification/pfl_host.sv
/*
  Host model driving the command port of the paged command bank.
  Assumes the bank takes a command on the edge that sees the strobe
  and answers in the following cycle.
*/
`timescale 1ns/1ps
module pfl_host (
  input  wire         sys_clk_i,
  input  wire  [15:0] rsp_data_i,
  input  wire         rsp_vld_i,
  input  wire         cmd_err_i,
  output logic        cmd_vld_o,
  output logic        cmd_wr_o,
  output logic [7:0]  cmd_code_o,
  output logic [15:0] cmd_wdata_o,
  output logic        page_o
);
  initial begin
    {cmd_vld_o, cmd_wr_o, cmd_code_o, cmd_wdata_o, page_o} = '0;
  end
  // Released code and data lines show the inverse so a stale value never matches.
  task automatic xfer(input logic w, input logic [7:0] c, input logic p,
                      input logic [15:0] d, output logic [15:0] rd,
                      output logic [1:0] ack);
    @(posedge sys_clk_i);
    #1;
    {cmd_vld_o, cmd_wr_o, cmd_code_o, cmd_wdata_o} = {1'b1, w, c, d};
    page_o = p;
    @(posedge sys_clk_i);
    #1;
    rd = rsp_data_i;
    ack = {rsp_vld_i, cmd_err_i};
    {cmd_vld_o, cmd_code_o, cmd_wdata_o} = {1'b0, ~c, ~d};
  endtask
endmodule

// ===== verification/pfl_bank_tb.sv
/*
  Self-checking bench for the paged fault and limit command bank.
  Assumes pfl_host drives the command port; fault flags and enables
  are driven here one nanosecond after each rising edge.
*/
`timescale 1ns/1ps
module pfl_bank_tb;
  logic        sys_clk;
  logic        rst;
  logic        vld, wr, pg, rv, er;
  logic [7:0]  code;
  logic [15:0] wd, rd;
  logic [1:0]  en, off;
  logic [17:0] cf;
  logic [6:0]  inf;
  logic [7:0]  act [3] = '{8'h40, 8'h80, 8'h00};
  logic [39:0] tbl [30] = '{
    40'h38_ca80_ca80, 40'h39_e801_e800, 40'h40_044a_04c5, 40'h41_0080_0080,
    40'h42_0429_04a4, 40'h43_02d1_034c, 40'h44_02c0_033b, 40'h45_0040_0040,
    40'h46_10e0_0050, 40'h47_00c0_00c0, 40'h4a_01b8_003c, 40'h4f_0078_0078,
    40'h50_0080_0080, 40'h51_006e_006e, 40'h55_000f_000f, 40'h56_0080_0080,
    40'h57_000e_000e, 40'h58_f022_f022, 40'h59_f020_f020, 40'h5a_0080_0080,
    40'h5b_0034_0034, 40'h5c_00c0_00c0, 40'h5d_002c_002c, 40'h60_f800_f800,
    40'h61_f006_f006, 40'h62_f008_f008, 40'h63_0080_0080, 40'h64_f800_f800,
    40'h65_f006_f006, 40'h6b_0928_0928};
  int          fails = 0;
  int          check_count = 0;
  int          cyc = 0;

  pfl_bank uut (.sys_clk_i(sys_clk), .rst_i(rst), .cmd_vld_i(vld),
    .cmd_wr_i(wr), .cmd_code_i(code), .cmd_wdata_i(wd), .page_i(pg),
    .chan_en_i(en), .chan_flt_i(cf), .in_flt_i(inf), .rsp_data_o(rd),
    .rsp_vld_o(rv), .cmd_err_o(er), .chan_off_o(off));
  pfl_host host_m (.sys_clk_i(sys_clk), .rsp_data_i(rd), .rsp_vld_i(rv),
    .cmd_err_i(er), .cmd_vld_o(vld), .cmd_wr_o(wr), .cmd_code_o(code),
    .cmd_wdata_o(wd), .page_o(pg));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      final_report;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic op(input logic w, input logic [7:0] c, input logic p,
                    input logic [15:0] d, input logic [1:0] ea,
                    input logic [15:0] ed);
    logic [15:0] got;
    logic [1:0]  ack;
    host_m.xfer(w, c, p, d, got, ack);
    chk({14'h0, ack}, {14'h0, ea});
    if (!w)
      chk(got, ed);
  endtask

  task automatic rdx(input logic [7:0] c, input logic p,
                     input logic [15:0] ed);
    op(1'b0, c, p, 16'h0, 2'b10, ed);
  endtask

  initial begin
    {rst, en, cf, inf} = {1'b1, 2'b11, 25'h0};
    tick(8);
    rst = 1'b0;
    for (int i = 0; i < 30; i++) begin
      rdx(tbl[i][39:32], 1'b0, tbl[i][31:16]);
      op(1'b0, tbl[i][39:32], 1'b1, 16'h0, 2'b10, tbl[i][15:0]);
    end
    for (int i = 0; i < 6; i++)
      op(1'b0, 8'h78 + i[7:0] / 2, i[0], 16'h0, 2'b10, 16'h0);
    $display("test defaults done");
    op(1'b1, 8'h40, 1'b0, 16'h1234, 2'b00, 16'h0);
    op(1'b0, 8'h40, 1'b0, 16'h0, 2'b10, 16'h1234);
    op(1'b0, 8'h40, 1'b1, 16'h0, 2'b10, 16'h04c5);
    op(1'b1, 8'h41, 1'b1, 16'hab80, 2'b00, 16'h0);
    op(1'b0, 8'h41, 1'b1, 16'h0, 2'b10, 16'h0080);
    op(1'b1, 8'h78, 1'b0, 16'h00ff, 2'b01, 16'h0);
    op(1'b0, 8'h78, 1'b0, 16'h0, 2'b10, 16'h0);
    op(1'b0, 8'h00, 1'b0, 16'h0, 2'b01, 16'h0);
    $display("test paging done");
    cf[0] = 1'b1;
    tick(2);
    chk({14'h0, off}, 16'h0);
    tick(1);
    chk({14'h0, off}, 16'h1);
    cf[0] = 1'b0;
    tick(8);
    chk({14'h0, off}, 16'h1);
    op(1'b0, 8'h79, 1'b0, 16'h0, 2'b10, 16'h8860);
    op(1'b0, 8'h7a, 1'b0, 16'h0, 2'b10, 16'h0080);
    op(1'b0, 8'h79, 1'b1, 16'h0, 2'b10, 16'h0);
    op(1'b1, 8'h79, 1'b0, 16'h0, 2'b00, 16'h0);
    chk({14'h0, off}, 16'h0);
    op(1'b0, 8'h79, 1'b0, 16'h0, 2'b10, 16'h0);
    $display("test overvoltage done");
    // Flags and enable settle for four cycles so the synchroniser drains.
    foreach (act[j]) begin
      op(1'b1, 8'h45, 1'b1, {8'h00, act[j]}, 2'b00, 16'h0);
      cf[12] = 1'b1;
      tick(4);
      chk({14'h0, off}, {14'h0, act[j][7], 1'b0});
      tick(96);
      chk({14'h0, off}, {14'h0, act[j][7], 1'b0});
      tick(8);
      chk({14'h0, off}, {14'h0, |act[j], 1'b0});
      {cf[12], en[1]} = 2'b00;
      tick(4);
      chk({14'h0, off}, 16'h0);
      en[1] = 1'b1;
    end
    $display("test undervoltage done");
    inf[0] = 1'b1;
    tick(4);
    chk({14'h0, off}, 16'h3);
    {inf[0], en} = 3'b000;
    tick(4);
    chk({14'h0, off}, 16'h0);
    en = 2'b11;
    tick(2);
    $display("test input fault done");
    op(1'b0, 8'h79, 1'b1, 16'h0, 2'b10, 16'ha000);
    op(1'b0, 8'h7a, 1'b1, 16'h0, 2'b10, 16'h0010);
    op(1'b1, 8'h7a, 1'b1, 16'h0, 2'b00, 16'h0);
    op(1'b0, 8'h79, 1'b1, 16'h0, 2'b10, 16'h2000);
    op(1'b1, 8'h79, 1'b1, 16'h0, 2'b00, 16'h0);
    op(1'b0, 8'h79, 1'b0, 16'h0, 2'b10, 16'h0);
    $display("test status clear done");
    final_report;
  end
endmodule
